// ### phy_diag_regs.sv
// Register bank for events, self-test, reflectometry and reset control.
// Assumes an AHB-Lite master on hclk; event inputs are already on hclk.
`timescale 1ns/1ps
`default_nettype none
module phy_diag_regs #(
    parameter int CNT_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic por_done_evt,
    input wire logic no_frame_evt,
    input wire logic low_power_sleep_event,
    input wire logic chk_err_byte,
    input wire logic err_cnt_mode,
    input wire logic tdr_done_in,
    input wire logic tdr_fail_in,
    output logic irq,
    output logic [9:0] gap_bytes,
    output logic [10:0] packet_len,
    output logic tdr_start,
    output logic phy_hw_reset,
    output logic phy_sw_restart,
    output logic standby
);
    if (CNT_W != 8) begin : bad_cnt_w
        $error("error count width must be 8");
    end

    // ****************************************************************
    // Bus decode and register state.
    // ****************************************************************
    logic wr_pend_r, wr_pend_nxt;
    logic [4:0] widx_r, widx_nxt;
    logic [2:0] stat_r, stat_nxt;
    logic [2:0] en_r, en_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] frz_r, frz_nxt;
    logic [7:0] gap_r, gap_nxt;
    logic [10:0] plen_r, plen_nxt;
    logic start_r, start_nxt;
    logic done_r, done_nxt;
    logic fail_r, fail_nxt;
    logic hwr_r, hwr_nxt;
    logic swr_r, swr_nxt;
    logic stby_r, stby_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;
    logic acc, rd_acc;
    logic [4:0] aidx;
    logic [15:0] wd;
    logic hw_wr, evt_rd;

    assign acc = hsel && hready && (htrans == phy_diag_pkg::HTRANS_NONSEQ);
    assign rd_acc = acc && !hwrite;
    assign aidx = haddr[6:2];
    assign wd = hwdata[15:0];
    assign hw_wr = wr_pend_r && (widx_r == phy_diag_pkg::IDX_RST) && wd[phy_diag_pkg::BIT_HWRST];
    assign evt_rd = rd_acc && (aidx == phy_diag_pkg::IDX_EVT);

    always_comb begin
        wr_pend_nxt = acc && hwrite;
        widx_nxt = acc ? aidx : widx_r;
        stat_nxt = stat_r;
        en_nxt = en_r;
        cnt_nxt = cnt_r;
        frz_nxt = frz_r;
        gap_nxt = gap_r;
        plen_nxt = plen_r;
        start_nxt = 1'b0;
        done_nxt = done_r;
        fail_nxt = fail_r;
        hwr_nxt = 1'b0;
        swr_nxt = 1'b0;
        stby_nxt = stby_r;
        rdata_nxt = rdata_r;
        if (rd_acc && aidx == phy_diag_pkg::IDX_EVT) begin
            stat_nxt = 3'h0; // RQ19
        end
        if (rd_acc) begin
            case (aidx)
                phy_diag_pkg::IDX_EVT: begin
                    rdata_nxt = {16'h0000, 3'h0, stat_r[2], stat_r[1], 2'h0, stat_r[0],
                                 3'h0, en_r[2], en_r[1], 2'h0, en_r[0]};
                end
                phy_diag_pkg::IDX_BIST1: begin
                    rdata_nxt = {16'h0000, frz_r, gap_r}; // RQ7
                end
                phy_diag_pkg::IDX_BIST2: begin
                    rdata_nxt = {16'h0000, 5'h00, plen_r};
                end
                phy_diag_pkg::IDX_TDR: begin
                    rdata_nxt = {16'h0000, start_r, 13'h0000, done_r, fail_r};
                end
                phy_diag_pkg::IDX_RST: begin
                    rdata_nxt = {16'h0000, hwr_r, swr_r, 6'h00, stby_r, 7'h00};
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
        if (chk_err_byte) begin
            if (cnt_r != 8'hff || err_cnt_mode) begin
                cnt_nxt = cnt_r + 8'h01; // RQ7 RQ9
            end
        end
        if (wr_pend_r) begin
            case (widx_r)
                phy_diag_pkg::IDX_EVT: begin
                    en_nxt = {wd[phy_diag_pkg::BIT_POR_EN], wd[phy_diag_pkg::BIT_NOF_EN],
                              wd[phy_diag_pkg::BIT_LPS_EN]}; // RQ4 RQ5 RQ6
                end
                phy_diag_pkg::IDX_BIST1: begin
                    gap_nxt = wd[7:0]; // RQ10
                    if (wd[phy_diag_pkg::BIT_LOCK]) begin
                        frz_nxt = cnt_r; // RQ8
                        cnt_nxt = {7'h00, chk_err_byte}; // RQ8
                    end
                end
                phy_diag_pkg::IDX_BIST2: begin
                    plen_nxt = wd[10:0]; // RQ11
                end
                phy_diag_pkg::IDX_TDR: begin
                    if (wd[phy_diag_pkg::BIT_START]) begin
                        start_nxt = 1'b1; // RQ12
                        done_nxt = 1'b0;
                        fail_nxt = 1'b0;
                    end
                end
                phy_diag_pkg::IDX_RST: begin
                    hwr_nxt = wd[phy_diag_pkg::BIT_HWRST]; // RQ15
                    swr_nxt = wd[phy_diag_pkg::BIT_SWRST]; // RQ16
                    stby_nxt = wd[phy_diag_pkg::BIT_STBY]; // RQ17
                end
                default: begin
                end
            endcase
        end
        if (hw_wr) begin
            stat_nxt = 3'h0; // RQ15
            en_nxt = phy_diag_pkg::EN_RST;
            cnt_nxt = 8'h00;
            frz_nxt = 8'h00;
            gap_nxt = phy_diag_pkg::GAP_RST;
            plen_nxt = phy_diag_pkg::PLEN_RST;
            done_nxt = 1'b0;
            fail_nxt = 1'b0;
            swr_nxt = 1'b0;
            stby_nxt = 1'b0;
        end
        if (tdr_done_in) begin
            done_nxt = 1'b1; // RQ13
        end
        if (tdr_fail_in) begin
            fail_nxt = 1'b1; // RQ14
        end
        if (por_done_evt) begin
            stat_nxt[2] = 1'b1; // RQ1
        end
        if (no_frame_evt) begin
            stat_nxt[1] = 1'b1; // RQ2
        end
        if (low_power_sleep_event) begin
            stat_nxt[0] = 1'b1; // RQ3
        end
        irq_nxt = |(stat_nxt & en_nxt); // RQ18
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            widx_r <= 5'h00;
            stat_r <= 3'h0;
            en_r <= phy_diag_pkg::EN_RST;
            cnt_r <= 8'h00;
            frz_r <= 8'h00;
            gap_r <= phy_diag_pkg::GAP_RST;
            plen_r <= phy_diag_pkg::PLEN_RST;
            start_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            hwr_r <= 1'b0;
            swr_r <= 1'b0;
            stby_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end else if (clk_en) begin
            wr_pend_r <= wr_pend_nxt;
            widx_r <= widx_nxt;
            stat_r <= stat_nxt;
            en_r <= en_nxt;
            cnt_r <= cnt_nxt;
            frz_r <= frz_nxt;
            gap_r <= gap_nxt;
            plen_r <= plen_nxt;
            start_r <= start_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
            hwr_r <= hwr_nxt;
            swr_r <= swr_nxt;
            stby_r <= stby_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = irq_r;
    assign gap_bytes = {gap_r, 2'b00}; // RQ10
    assign packet_len = plen_r;
    assign tdr_start = start_r;
    assign phy_hw_reset = hwr_r;
    assign phy_sw_restart = swr_r;
    assign standby = stby_r;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    property p_irq_follows;
        @(posedge hclk) disable iff (!hresetn)
        irq == |(stat_r & en_r);
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch"); // RQ18

    property p_por_latch;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && por_done_evt) |=> stat_r[2];
    endproperty
    a_por_latch: assert property (p_por_latch) else $error("por not latched"); // RQ1

    property p_nof_latch;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && no_frame_evt) |=> stat_r[1];
    endproperty
    a_nof_latch: assert property (p_nof_latch) else $error("no-frame not latched"); // RQ2

    property p_lps_latch;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && low_power_sleep_event) |=> stat_r[0];
    endproperty
    a_lps_latch: assert property (p_lps_latch) else $error("sleep not latched"); // RQ3

    property p_read_clear;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && rd_acc && aidx == phy_diag_pkg::IDX_EVT && !por_done_evt) |=> !stat_r[2];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared"); // RQ19

    property p_sat;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && cnt_r == 8'hff && !err_cnt_mode && !wr_pend_r) |=> cnt_r == 8'hff;
    endproperty
    a_sat: assert property (p_sat) else $error("counter wrapped"); // RQ9

    property p_start_sc;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && tdr_start) |=> (!tdr_start || $past(wr_pend_r));
    endproperty
    a_start_sc: assert property (p_start_sc) else $error("start not self-cleared"); // RQ12

    property p_hw_sc;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && phy_hw_reset && !wr_pend_r) |=> !phy_hw_reset;
    endproperty
    a_hw_sc: assert property (p_hw_sc) else $error("hw reset stuck"); // RQ15

    property p_gap;
        @(posedge hclk) disable iff (!hresetn)
        gap_bytes == 10'(gap_r) * 10'(phy_diag_pkg::GAP_UNIT);
    endproperty
    a_gap: assert property (p_gap) else $error("gap wrong"); // RQ10

    property p_stat_hold;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !evt_rd && !hw_wr) |=> (stat_r & $past(stat_r)) == $past(stat_r);
    endproperty
    a_stat_hold: assert property (p_stat_hold) else $error("status bit dropped"); // RQ1 RQ2 RQ3

    property p_nof_clear;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt_rd && !no_frame_evt) |=> !stat_r[1];
    endproperty
    a_nof_clear: assert property (p_nof_clear) else $error("no-frame not cleared"); // RQ19

    property p_lps_clear;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && evt_rd && !low_power_sleep_event) |=> !stat_r[0];
    endproperty
    a_lps_clear: assert property (p_lps_clear) else $error("sleep not cleared"); // RQ19

    property p_sw_sc;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && phy_sw_restart && !wr_pend_r) |=> !phy_sw_restart;
    endproperty
    a_sw_sc: assert property (p_sw_sc) else $error("restart stuck"); // RQ16

    property p_done_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && tdr_done_in) |=> done_r;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set"); // RQ13

    property p_fail_set;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && tdr_fail_in) |=> fail_r;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail not set"); // RQ14

    property p_done_hold;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && done_r && !wr_pend_r) |=> done_r;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("done dropped"); // RQ13

    property p_wrap;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && chk_err_byte && err_cnt_mode && !wr_pend_r) |=> cnt_r == $past(cnt_r) + 8'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count not advanced"); // RQ7

    property p_cnt_idle;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !chk_err_byte && !wr_pend_r) |=> cnt_r == $past(cnt_r);
    endproperty
    a_cnt_idle: assert property (p_cnt_idle) else $error("count moved"); // RQ7

    property p_lock;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_r && widx_r == phy_diag_pkg::IDX_BIST1 && wd[phy_diag_pkg::BIT_LOCK] && !chk_err_byte)
        |=> (cnt_r == 8'h00) && (frz_r == $past(cnt_r));
    endproperty
    a_lock: assert property (p_lock) else $error("lock failed"); // RQ8

    property p_stby_on;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_r && widx_r == phy_diag_pkg::IDX_RST && wd[phy_diag_pkg::BIT_STBY] && !hw_wr)
        |=> standby;
    endproperty
    a_stby_on: assert property (p_stby_on) else $error("standby not entered"); // RQ17

    property p_stby_hold;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && !(wr_pend_r && widx_r == phy_diag_pkg::IDX_RST)) |=> standby == $past(standby);
    endproperty
    a_stby_hold: assert property (p_stby_hold) else $error("standby moved"); // RQ17

    property p_hw_regs;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && hw_wr) |=> (plen_r == phy_diag_pkg::PLEN_RST) && (gap_r == phy_diag_pkg::GAP_RST) && !standby;
    endproperty
    a_hw_regs: assert property (p_hw_regs) else $error("registers not reset"); // RQ15

    property p_en_write;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_r && widx_r == phy_diag_pkg::IDX_EVT) |=> en_r == {$past(wd[phy_diag_pkg::BIT_POR_EN]),
            $past(wd[phy_diag_pkg::BIT_NOF_EN]), $past(wd[phy_diag_pkg::BIT_LPS_EN])};
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost"); // RQ4 RQ5 RQ6

    property p_gap_write;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_r && widx_r == phy_diag_pkg::IDX_BIST1) |=> gap_bytes == {$past(wd[7:0]), 2'b00};
    endproperty
    a_gap_write: assert property (p_gap_write) else $error("gap write lost"); // RQ10

    property p_plen_write;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && wr_pend_r && widx_r == phy_diag_pkg::IDX_BIST2) |=> packet_len == $past(wd[10:0]);
    endproperty
    a_plen_write: assert property (p_plen_write) else $error("length write lost"); // RQ11
endmodule
`default_nettype wire

// ### phy_diag_pkg.sv
// Constants for the PHY diagnostic, interrupt and reset register bank.
// Assumes an AHB-Lite master with 32-bit words; printed offsets are register indices.
// What this block does
// (RQ1) Latch reset-done event at status bit 12.
// (RQ2) Latch no-frame event at status bit 11.
// (RQ3) Latch sleep event at status bit 8.
// (RQ4) Enable bit 4 gates reset-done, resets one.
// (RQ5) Enable bit 3 gates no-frame, resets zero.
// (RQ6) Enable bit 0 gates sleep event, resets zero.
// (RQ7) Count checker errored bytes into bits 15:8.
// (RQ8) Writing bit 15 freezes count, clears counter.
// (RQ9) Counter mode zero saturates the error counter.
// (RQ10) Generator gap is field 7:0 times four.
// (RQ11) Generator packet length from bits 10:0.
// (RQ12) Write bit 15 starts reflectometry, self-clears.
// (RQ13) Done bit 1 set when measurement completes.
// (RQ14) Fail bit 0 set when measurement fails.
// (RQ15) Bit 15 resets whole PHY, self-clears.
// (RQ16) Bit 14 restarts circuitry, keeps registers.
// (RQ17) Bit 7 selects standby mode.
// (RQ18) Interrupt when enabled status bit set.
// (RQ19) Reading status register clears latched bits.
package phy_diag_pkg;
    localparam logic [4:0] IDX_EVT = 5'h18;
    localparam logic [4:0] IDX_BIST1 = 5'h1b;
    localparam logic [4:0] IDX_BIST2 = 5'h1c;
    localparam logic [4:0] IDX_TDR = 5'h1e;
    localparam logic [4:0] IDX_RST = 5'h1f;
    localparam int BIT_POR = 12;
    localparam int BIT_NOF = 11;
    localparam int BIT_LPS = 8;
    localparam int BIT_POR_EN = 4;
    localparam int BIT_NOF_EN = 3;
    localparam int BIT_LPS_EN = 0;
    localparam int BIT_LOCK = 15;
    localparam int BIT_START = 15;
    localparam int BIT_DONE = 1;
    localparam int BIT_FAIL = 0;
    localparam int BIT_HWRST = 15;
    localparam int BIT_SWRST = 14;
    localparam int BIT_STBY = 7;
    localparam logic [7:0] GAP_RST = 8'h7d;
    localparam logic [10:0] PLEN_RST = 11'h5ee;
    localparam logic [2:0] EN_RST = 3'h4;
    localparam int GAP_UNIT = 4;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### phy_diag_regs_bench.sv
// Self-checking bench for the diagnostic, interrupt and reset register bank.
// Assumes one zero-wait AHB-Lite slave and event pulses on hclk.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module phy_diag_regs_bench;
    // ********************
    // Signals.
    // ********************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [5:0] ev = 6'h0;
    logic err_cnt_mode = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, irq, tdr_start, phy_hw_reset, phy_sw_restart, standby;
    logic [9:0] gap_bytes;
    logic [10:0] packet_len;
    logic [7:0] g;
    logic [10:0] pl;
    int bad_count = 0;
    int cmp_count = 0;
    int n_start = 0, n_hw = 0, n_sw = 0, n;
    int stb[3] = '{12, 11, 8};
    int enb[3] = '{4, 3, 0};

    phy_diag_regs i_dut (
        .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .por_done_evt(ev[0]), .no_frame_evt(ev[1]),
        .low_power_sleep_event(ev[2]), .chk_err_byte(ev[3]), .err_cnt_mode(err_cnt_mode),
        .tdr_done_in(ev[4]), .tdr_fail_in(ev[5]), .irq(irq), .gap_bytes(gap_bytes),
        .packet_len(packet_len), .tdr_start(tdr_start), .phy_hw_reset(phy_hw_reset),
        .phy_sw_restart(phy_sw_restart), .standby(standby)
    );

    initial begin
        forever #12.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        n_start += (tdr_start === 1'b1);
        n_hw += (phy_hw_reset === 1'b1);
        n_sw += (phy_sw_restart === 1'b1);
    end

    // ********************
    // Tasks and expectations.
    // ********************
    function automatic logic [7:0] exp_cnt(input int k, input logic mode);
        return (mode || k < 256) ? k[7:0] : 8'hff;
    endfunction

    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 50) begin
                bad_count++;
                close_out();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
        htrans <= phy_diag_pkg::HTRANS_NONSEQ;
        haddr <= {25'h0, idx, 2'h0};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic chk_rd(input string nm, input logic [4:0] idx, input logic [31:0] ex);
        bus(1'b0, idx, 32'h0);
        `CHK(nm, ex, rd)
    endtask

    task automatic pulse(input int i, input int cnt);
        repeat (cnt) begin
            ev[i] <= 1'b1;
            @(posedge hclk);
            ev[i] <= 1'b0;
            @(posedge hclk);
        end
    endtask

    task automatic wait_irq(input logic v);
        int k;
        k = 0;
        while (irq !== v && k < 10) begin
            @(posedge hclk);
            k++;
        end
        `CHK("irq", v, irq)
        if (irq !== v) begin
            close_out();
        end
    endtask

    // ********************
    // Test sequence.
    // ********************
    initial begin
        void'($urandom(66));
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_rd("evt", phy_diag_pkg::IDX_EVT, 32'h10);
        chk_rd("bist1", phy_diag_pkg::IDX_BIST1, 32'h7d);
        chk_rd("bist2", phy_diag_pkg::IDX_BIST2, 32'h5ee);
        chk_rd("tdr", phy_diag_pkg::IDX_TDR, 32'h0);
        chk_rd("rst", phy_diag_pkg::IDX_RST, 32'h0);
        `CHK("gap_bytes", 10'h1f4, gap_bytes)
        `CHK("irq", 1'b0, irq)
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, phy_diag_pkg::IDX_EVT, 32'h0);
            pulse(i, 1);
            repeat (3) @(posedge hclk);
            `CHK("masked", 1'b0, irq)
            bus(1'b1, phy_diag_pkg::IDX_EVT, 32'h1 << enb[i]);
            wait_irq(1'b1);
            chk_rd("status", phy_diag_pkg::IDX_EVT, (32'h1 << stb[i]) | (32'h1 << enb[i]));
            wait_irq(1'b0);
            chk_rd("cleared", phy_diag_pkg::IDX_EVT, 32'h1 << enb[i]);
        end
        clk_en <= 1'b0;
        pulse(2, 1);
        clk_en <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK("frozen_irq", 1'b0, irq)
        chk_rd("frozen", phy_diag_pkg::IDX_EVT, 32'h1);
        $display("test events done");
        g = 8'($urandom_range(255));
        n = $urandom_range(200, 1);
        pulse(3, n);
        bus(1'b1, phy_diag_pkg::IDX_BIST1, {16'h0, 8'h80, g});
        chk_rd("count", phy_diag_pkg::IDX_BIST1, {16'h0, exp_cnt(n, 1'b0), g});
        `CHK("gap_bytes", {g, 2'h0}, gap_bytes)
        for (int m = 0; m < 2; m++) begin
            err_cnt_mode <= m[0];
            pulse(3, 300 - 40 * m);
            bus(1'b1, phy_diag_pkg::IDX_BIST1, {16'h0, 8'h80, g});
            chk_rd("count", phy_diag_pkg::IDX_BIST1, {16'h0, exp_cnt(300 - 40 * m, m[0]), g});
        end
        bus(1'b1, phy_diag_pkg::IDX_BIST1, {16'h0, 8'h80, g});
        chk_rd("count_clr", phy_diag_pkg::IDX_BIST1, {16'h0, 8'h0, g});
        pl = 11'($urandom_range(2047));
        bus(1'b1, phy_diag_pkg::IDX_BIST2, 32'hffff_f800 | {21'h0, pl});
        chk_rd("plen", phy_diag_pkg::IDX_BIST2, {21'h0, pl});
        `CHK("packet_len", pl, packet_len)
        $display("test selftest done");
        bus(1'b1, phy_diag_pkg::IDX_TDR, 32'h8000);
        repeat (3) @(posedge hclk);
        `CHK("start", 1, n_start)
        chk_rd("tdr", phy_diag_pkg::IDX_TDR, 32'h0);
        pulse(4, 1);
        chk_rd("tdr_done", phy_diag_pkg::IDX_TDR, 32'h2);
        pulse(5, 1);
        chk_rd("tdr_fail", phy_diag_pkg::IDX_TDR, 32'h3);
        $display("test reflect done");
        bus(1'b1, phy_diag_pkg::IDX_RST, 32'h4080);
        repeat (3) @(posedge hclk);
        `CHK("restart", 1, n_sw)
        `CHK("standby", 1'b1, standby)
        chk_rd("rst", phy_diag_pkg::IDX_RST, 32'h80);
        chk_rd("plen_kept", phy_diag_pkg::IDX_BIST2, {21'h0, pl});
        bus(1'b1, 5'h19, 32'hffff);
        chk_rd("unmapped", 5'h19, 32'h0);
        bus(1'b1, phy_diag_pkg::IDX_RST, 32'h8000);
        repeat (3) @(posedge hclk);
        `CHK("hw_reset", 1, n_hw)
        `CHK("standby_off", 1'b0, standby)
        chk_rd("plen_reset", phy_diag_pkg::IDX_BIST2, 32'h5ee);
        chk_rd("evt_reset", phy_diag_pkg::IDX_EVT, 32'h10);
        chk_rd("bist1_reset", phy_diag_pkg::IDX_BIST1, 32'h7d);
        chk_rd("tdr_reset", phy_diag_pkg::IDX_TDR, 32'h0);
        $display("test reset control done");
        close_out();
    end
endmodule
`default_nettype wire
